//--- logic/flash_link_pkg.sv
// Shared constants for the serial flash link: opcodes, layouts, reset values
package flash_link_pkg;
    localparam int byte_bits = 8;
    localparam int addr_bits = 24;
    localparam int bit_count_bits = 3;
    localparam logic [7:0] op_read = 8'h03;
    localparam logic [7:0] op_read_id = 8'h90;
    localparam logic [7:0] op_read_status = 8'h05;
    localparam logic [7:0] op_write_enable = 8'h06;
    localparam logic [7:0] status_write_cmd = 8'h01;
    localparam logic [23:0] id_addr_maker = 24'h00_0000;
    localparam logic [23:0] id_addr_part = 24'h00_0001;
    localparam int lock_pos = 7;
    localparam int level_hi_pos = 3;
    localparam int level_lo_pos = 2;
    localparam logic [1:0] level_reset = 2'h3;
    localparam logic lock_reset = 1'h0;
    localparam logic [23:0] sector_bytes = 24'h00_1000;
    localparam logic [23:0] block_bytes = 24'h00_8000;
    localparam logic [23:0] array_bytes = 24'h01_0000;
    localparam logic [23:0] quarter_base = 24'h00_C000;
    localparam logic [23:0] half_base = 24'h00_8000;
    localparam int sck_div = 4;
    localparam logic [1:0] level_none = 2'h0;
    localparam logic [1:0] level_quarter = 2'h1;
    localparam logic [1:0] level_half = 2'h2;
    // Host control register offsets (byte addresses)
    localparam logic [3:0] reg_ctrl = 4'h0;
    localparam logic [3:0] reg_tx = 4'h4;
    localparam logic [3:0] reg_rx = 4'h8;
    localparam logic [3:0] reg_stat = 4'hC;
    localparam int ctrl_start_pos = 0;
    localparam int ctrl_sel_pos = 1;
    localparam int ctrl_pause_pos = 2;
    localparam int ctrl_wp_pos = 3;
    localparam int ctrl_mode3_pos = 4;
    localparam logic [7:0] ctrl_reset = 8'h0E;
endpackage

//--- logic/flash_link_if.sv
// Four-wire serial link plus pause and write-protect lines
`timescale 1ns/1ps
interface flash_link_if;
    logic sck;
    logic sel_b;
    logic mosi;
    logic pause_b;
    logic wp_b;
    logic miso_o;
    logic miso_oe_b;
    logic miso;
    assign miso = miso_oe_b ? 1'b1 : miso_o;
    modport flash (input sck, input sel_b, input mosi, input pause_b, input wp_b,
        output miso_o, output miso_oe_b);
    modport host (output sck, output sel_b, output mosi, output pause_b, output wp_b,
        input miso);
endinterface

//--- logic/flash_end.sv
// Flash-side serial front end: command capture, id read, status protection, pause
// Notes on behaviour
// - Sample input bits on rising clock edge
// - Launch output bits after falling clock edge
// - Select only on falling select edge
// - Host keeps select low whole command
// - Works in mode 0 and mode 3
// - Id bytes at id addresses 0, 1
// - Array split in 4K sectors, 32K blocks
// - Pause only while selected
// - Pause entry during clock low phase
// - Pause exit during clock low phase
// - Paused: output off, inputs ignored
// - Pause freezes sequence state
// - Select high while paused resets interface
// - Host releases pause with select low
// - Status write refused on wp low, lock
// - Level bits and lock guard writes
// - Level decode; levels set after reset
// - Lock clear at reset; locked bits frozen
// - Early select rise aborts command
// - Eight-bit cycles, MSB first
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
module flash_end #(
    parameter logic [7:0] maker_id = 8'h5A,  // Arbitrary value
    parameter logic [7:0] part_id = 8'h21    // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst_b,
    flash_link_if.flash link,
    output logic [7:0] status,
    output logic [23:0] write_addr,
    output logic write_allowed,
    output logic [11:0] sector_index,
    output logic [0:0] block_index,
    output logic paused
);
    import flash_link_pkg::*;

    typedef enum logic [3:0] {
        st_op = 4'b0001,
        st_addr = 4'b0010,
        st_data = 4'b0100,
        st_out = 4'b1000
    } phase_type;

    logic [1:0] sck_s, sel_s, mosi_s, pause_s, wp_s;
    logic sck_d, sel_d;
    phase_type phase;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] shift_in, opcode, shift_out;
    logic [23:0] addr;
    logic selected, write_en_latch, lock, drive;
    logic [1:0] level;

    // Two-flop synchronisers for every pin
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sck_s <= 2'h0;
            sel_s <= 2'h3;
            mosi_s <= 2'h0;
            pause_s <= 2'h3;
            wp_s <= 2'h3;
            sck_d <= 1'b0;
            sel_d <= 1'b1;
        end else begin
            sck_s <= {sck_s[0], link.sck};
            sel_s <= {sel_s[0], link.sel_b};
            mosi_s <= {mosi_s[0], link.mosi};
            pause_s <= {pause_s[0], link.pause_b};
            wp_s <= {wp_s[0], link.wp_b};
            sck_d <= sck_s[1];
            sel_d <= sel_s[1];
        end
    end

    wire sck_v = sck_s[1];
    wire sel_b_v = sel_s[1];
    wire si_v = mosi_s[1];
    wire sel_fall = sel_d && !sel_b_v;
    wire sel_rise = !sel_d && sel_b_v;
    // Pause state follows the pin only while clock is low and selected
    wire next_paused = (!sck_v && !sel_b_v) ? !pause_s[1] : paused;
    wire active = selected && !paused && !sel_b_v;
    wire rise = active && sck_v && !sck_d;
    wire fall = active && !sck_v && sck_d;
    wire [7:0] byte_in = {shift_in[6:0], si_v};
    wire byte_done = rise && (bit_cnt == 3'h7);
    wire wp_low = !wp_s[1];
    wire status_ok = !(wp_low && lock);
    wire is_read = (opcode == op_read) || (opcode == op_read_id);
    wire [7:0] id_byte = (addr == id_addr_maker) ? maker_id :
                         (addr == id_addr_part) ? part_id : 8'h00;
    wire [7:0] load_byte = (opcode == op_read_status) ? status :
                           (opcode == op_read_id) ? id_byte : 8'h00;

    assign status = {lock, 1'b0, 2'h0, level, write_en_latch, 1'b0};
    assign link.miso_o = shift_out[7];
    assign link.miso_oe_b = !(drive && active);
    assign write_addr = addr;
    assign sector_index = addr[23:12];
    assign block_index = addr[15];
    // Protected region by level bits
    assign write_allowed = write_en_latch &&
        ((level == level_none) ||
         (level == level_quarter && addr < quarter_base) ||
         (level == level_half && addr < half_base));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            paused <= 1'b0;
        end else if (sel_b_v) begin
            paused <= 1'b0;
        end else begin
            paused <= next_paused;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            selected <= 1'b0;
            phase <= st_op;
            bit_cnt <= 3'h0;
            byte_cnt <= 2'h0;
            shift_in <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h00_0000;
            shift_out <= 8'h00;
            drive <= 1'b0;
        end else if (sel_b_v || sel_fall) begin
            // Rising select (even mid byte or paused) abandons the command
            selected <= sel_fall;
            phase <= st_op;
            bit_cnt <= 3'h0;
            byte_cnt <= 2'h0;
            drive <= 1'b0;
        end else if (rise) begin
            shift_in <= byte_in;
            bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
                unique case (phase)
                    st_op: begin
                        opcode <= byte_in;
                        if (byte_in == op_read || byte_in == op_read_id) begin
                            phase <= st_addr;
                        end else if (byte_in == op_read_status) begin
                            phase <= st_out;
                        end else begin
                            phase <= st_data;
                        end
                    end
                    st_addr: begin
                        addr <= {addr[15:0], byte_in};
                        byte_cnt <= byte_cnt + 2'h1;
                        if (byte_cnt == 2'h2) begin
                            phase <= st_out;
                        end
                    end
                    st_data, st_out: begin
                    end
                endcase
            end
        end else if (fall) begin
            if (phase == st_out && bit_cnt == 3'h0) begin
                // Reload at byte boundary; read steps the address up, id read toggles address bit 0
                shift_out <= load_byte;
                drive <= 1'b1;
                if (is_read && opcode != op_read_id) begin
                    addr <= addr + 24'h00_0001;
                end else if (opcode == op_read_id) begin
                    addr <= {addr[23:1], ~addr[0]};
                end
            end else begin
                shift_out <= {shift_out[6:0], 1'b0};
            end
        end
    end

    // Status register: lock and level commit only on whole data bytes after the opcode
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock <= lock_reset;
            level <= level_reset;
            write_en_latch <= 1'b0;
        end else if (byte_done && phase == st_op && byte_in == op_write_enable) begin
            write_en_latch <= 1'b1;
        end else if (byte_done && phase == st_data && opcode == status_write_cmd) begin
            if (status_ok) begin
                lock <= byte_in[lock_pos];
                level <= {byte_in[level_hi_pos], byte_in[level_lo_pos]};
            end
            write_en_latch <= 1'b0;
        end
    end
endmodule

//--- logic/spi_host_end.sv
// Host-side serial controller driven from Avalon-MM registers
`timescale 1ns/1ps
module spi_host_end (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    flash_link_if.host link
);
    import flash_link_pkg::*;

    typedef enum logic [1:0] {
        hs_idle = 2'b01,
        hs_shift = 2'b10
    } host_state_type;

    host_state_type state;
    logic [7:0] ctrl, tx, rx;
    logic [2:0] div_cnt;
    logic [3:0] edge_cnt;
    logic sck_q;
    logic [1:0] miso_s;
    logic [1:0] samp_dly;

    wire shifting = (state == hs_shift);
    wire busy = shifting || (samp_dly != 2'h0);
    wire wr_ctrl = write && address == reg_ctrl;
    wire wr_tx = write && address == reg_tx;
    wire start = wr_ctrl && writedata[ctrl_start_pos] && !busy;
    wire tick = (div_cnt == 3'(sck_div - 1));
    wire idle_level = ctrl[ctrl_mode3_pos];
    wire sck_rise = shifting && tick && !sck_q;
    // Mode 3 opens with a falling edge that must not push out the MSB
    wire shift_tx = sck_q && (edge_cnt != 4'h0);

    assign waitrequest = 1'b0;
    assign link.sck = shifting ? sck_q : idle_level;
    // Control bits carry pin levels, so reset leaves the link deselected
    assign link.sel_b = ctrl[ctrl_sel_pos];
    assign link.pause_b = ctrl[ctrl_pause_pos];
    assign link.wp_b = ctrl[ctrl_wp_pos];
    assign link.mosi = tx[7];

    always_comb begin
        unique case (address)
            reg_ctrl: readdata = {24'h00_0000, ctrl};
            reg_tx: readdata = {24'h00_0000, tx};
            reg_rx: readdata = {24'h00_0000, rx};
            reg_stat: readdata = {31'h0000_0000, busy};
            default: readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            miso_s <= 2'h0;
        end else begin
            miso_s <= {miso_s[0], link.miso};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= ctrl_reset;
        end else if (wr_ctrl) begin
            ctrl <= {writedata[7:1], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= hs_idle;
            tx <= 8'h00;
            div_cnt <= 3'h0;
            edge_cnt <= 4'h0;
            sck_q <= 1'b0;
        end else if (state == hs_idle) begin
            if (wr_tx) begin
                tx <= writedata[7:0];
            end
            if (start) begin
                state <= hs_shift;
                div_cnt <= 3'h0;
                edge_cnt <= 4'h0;
                sck_q <= writedata[ctrl_mode3_pos];
            end
        end else if (tick) begin
            div_cnt <= 3'h0;
            sck_q <= !sck_q;
            edge_cnt <= edge_cnt + 4'h1;
            if (shift_tx) begin
                tx <= {tx[6:0], 1'b0};
            end
            if (edge_cnt == 4'hF) begin
                state <= hs_idle;
            end
        end else begin
            div_cnt <= div_cnt + 3'h1;
        end
    end

    // The answer needs about five clocks through both synchronisers,
    // more than half a period, so sample two clocks after the rising edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            samp_dly <= 2'h0;
            rx <= 8'h00;
        end else begin
            samp_dly <= {samp_dly[0], sck_rise};
            if (samp_dly[1]) begin
                rx <= {rx[6:0], miso_s[1]};
            end
        end
    end
endmodule

//--- tb/flash_link_asserts.sv
// Checks on the serial link between the host end and the flash end
`timescale 1ns/1ps
module flash_link_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sck,
    input wire logic sel_b,
    input wire logic mosi,
    input wire logic pause_b,
    input wire logic wp_b,
    input wire logic miso_o,
    input wire logic miso_oe_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence high_half;
        sck [*4];
    endsequence
    sequence low_half;
        !sck [*4];
    endsequence
    a_sck_high_half: assert property ($rose(sck) |-> high_half)
        else $error("serial clock high phase not four clocks");
    a_sck_low_half: assert property ($fell(sck) |-> low_half)
        else $error("serial clock low phase not four clocks");
    a_oe_off_idle: assert property (sel_b && $past(sel_b, 3) |-> miso_oe_b)
        else $error("data out driven while deselected");
    a_out_on_low: assert property (!miso_oe_b && $past(!miso_oe_b) && $changed(miso_o)
        |-> !sck)
        else $error("data out changed outside clock low phase");
    a_in_stable_rise: assert property ($rose(sck) |-> $stable(mosi))
        else $error("data in moved at sampling edge");
    a_sel_held_byte: assert property ($fell(sck) |-> !sel_b)
        else $error("clock edge while deselected");
    a_pause_selected: assert property ($fell(pause_b) |-> !sel_b)
        else $error("pause asserted while deselected");
    a_sel_fall_quiet: assert property ($fell(sel_b) |-> $stable(sck))
        else $error("clock moved with select edge");
endmodule

//--- tb/tb_serial_flash_spi_front_end.sv
// Bench: software drives the host end over Avalon-MM, host end talks to the flash end
`timescale 1ns/1ps
module tb_serial_flash_spi_front_end;
    import flash_link_pkg::*;
    localparam logic [7:0] maker = 8'hA7; // Arbitrary value
    localparam logic [7:0] part = 8'h3C;  // Arbitrary value
    logic clk = 1'b0, rst_b = 1'b0, read = 1'b0, write = 1'b0, waitrequest;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0000_0000, readdata;
    logic [7:0] status, cfg, r;
    logic [23:0] write_addr;
    logic [11:0] sector_index;
    logic [0:0] block_index;
    logic write_allowed, paused;
    int err_total = 0, n_tests = 0;
    flash_link_if link_bus ();
    spi_host_end spi_host_end_inst (.clk(clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .link(link_bus));
    flash_end #(.maker_id(maker), .part_id(part)) flash_end_inst (.clk(clk), .rst_b(rst_b),
        .link(link_bus), .status(status), .write_addr(write_addr),
        .write_allowed(write_allowed), .sector_index(sector_index),
        .block_index(block_index), .paused(paused));
    flash_link_asserts flash_link_asserts_inst (.clk(clk), .rst_b(rst_b), .sck(link_bus.sck),
        .sel_b(link_bus.sel_b), .mosi(link_bus.mosi), .pause_b(link_bus.pause_b),
        .wp_b(link_bus.wp_b), .miso_o(link_bus.miso_o), .miso_oe_b(link_bus.miso_oe_b));
    initial forever #20 clk = ~clk;
    task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Answer is read at the accepting edge, before that edge's own updates
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        logic done;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        done = 1'b0;
        while (!done) begin
            @(posedge clk);
            done = (waitrequest === 1'b0);
            q = readdata;
        end
        write <= 1'b0;
        read <= 1'b0;
    endtask
    // Control byte holds pin levels: {mode3, wp_b, pause_b, sel_b, start}
    task set_cfg(input logic [7:0] c);
        logic [31:0] q;
        cfg = c;
        bus(1'b1, reg_ctrl, {24'h00_0000, c}, q);
    endtask
    task xfer(input logic [7:0] t, output logic [7:0] rx);
        logic [31:0] q;
        bus(1'b1, reg_tx, {24'h00_0000, t}, q);
        bus(1'b1, reg_ctrl, {24'h00_0000, cfg | 8'h01}, q);
        do bus(1'b0, reg_stat, 32'h0000_0000, q);
        while (q[0] !== 1'b0);
        bus(1'b0, reg_rx, 32'h0000_0000, q);
        rx = q[7:0];
    endtask
    // Flash sees the link a few clocks late, so let the last bit land first
    task desel;
        repeat (6) @(posedge clk);
        set_cfg(cfg | 8'h02);
        repeat (6) @(posedge clk);
    endtask
    task status_write(input logic w, input logic [7:0] d);
        set_cfg({4'h0, w, 3'b100});
        xfer(op_write_enable, r);
        desel();
        set_cfg({4'h0, w, 3'b100});
        xfer(status_write_cmd, r);
        xfer(d, r);
        desel();
    endtask
    task id_read(input logic m);
        set_cfg({3'h0, m, 4'hE});
        set_cfg({3'h0, m, 4'hC});
        xfer(op_read_id, r);
        repeat (3) xfer(8'h00, r);
        xfer(8'h00, r);
        check("maker id", 24'(r), 24'(maker));
        xfer(8'h00, r);
        check("part id", 24'(r), 24'(part));
        desel();
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        check("status at reset", 24'(status), 24'h00_000C);
        check("select idle", 24'(link_bus.sel_b), 24'h00_0001);
        check("out off at reset", 24'(link_bus.miso_oe_b), 24'h00_0001);
        cfg = 8'h0E;
        id_read(1'b0);
        status_write(1'b1, 8'h80);
        check("lock set", 24'(status & 8'h8C), 24'h00_0080);
        status_write(1'b0, 8'h0C);
        check("locked write refused", 24'(status & 8'h8C), 24'h00_0080);
        status_write(1'b1, 8'h00);
        check("wp high overrides lock", 24'(status & 8'h8C), 24'h00_0000);
        set_cfg(8'h0C);
        xfer(op_write_enable, r);
        desel();
        set_cfg(8'h0C);
        xfer(op_read, r);
        xfer(8'h00, r);
        xfer(8'h91, r);
        xfer(8'h23, r);
        // Mode 0: the closing falling edge fetches the first byte and steps the address
        check("address", write_addr, 24'h00_9124);
        check("write allowed", 24'(write_allowed), 24'h00_0001);
        check("sector", 24'(sector_index), 24'h00_0009);
        check("block", 24'(block_index), 24'h00_0001);
        desel();
        set_cfg(8'h0C);
        xfer(op_read_status, r);
        set_cfg(8'h08);
        repeat (8) @(posedge clk);
        check("paused", 24'(paused), 24'h00_0001);
        check("out off paused", 24'(link_bus.miso_oe_b), 24'h00_0001);
        set_cfg(8'h0C);
        repeat (8) @(posedge clk);
        check("resumed", 24'(paused), 24'h00_0000);
        xfer(8'h00, r);
        check("status after pause", 24'(r), 24'h00_0002);
        set_cfg(8'h08);
        repeat (8) @(posedge clk);
        set_cfg(8'h0A);
        repeat (8) @(posedge clk);
        check("deselect clears pause", 24'(paused), 24'h00_0000);
        set_cfg(8'h0E);
        id_read(1'b1);
        close_out();
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule
